// *** design/fsp_seq.sv ***
// Flash self-programming sequencer: address split, boot map, timing and busy control.
module fsp_seq
   import fsp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Core control
   input  wire logic        ctrl_wr,
   input  wire logic [4:0]  ctrl_wdata,
   input  wire logic        store_exec,
   input  wire logic        load_exec,
   input  wire logic [15:0] pointer,
   input  wire logic        power_down,
   // Configuration
   input  wire logic        boot_size_sel_hi,
   input  wire logic        boot_size_sel_lo,
   // Status
   output logic             store_enable,
   output logic             region_busy_flag,
   output logic [4:0]       ctrl_rdata,
   output logic             fetch_stall,
   output logic             flash_busy,
   // Flash address, strobes and boot map
   output fsp_addr_t        addr_out,
   output logic             erase_strobe,
   output logic             write_strobe,
   output logic             lock_strobe,
   output logic             load_strobe,
   output logic             reenable_strobe,
   output fsp_boot_t        boot_map
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic in_halt_region(input logic [6:0] page);
      in_halt_region = {page, 5'h00} >= HALT_REGION_BASE;
   endfunction

   function automatic fsp_boot_t boot_decode(input logic [1:0] sel);
      fsp_boot_t b;
      b = '0;
      unique case (sel)
         2'b11: begin b.boot_start = 12'h0F80; b.boot_words = 11'h080; b.boot_pages = 6'd4;  end
         2'b10: begin b.boot_start = 12'h0F00; b.boot_words = 11'h100; b.boot_pages = 6'd8;  end
         2'b01: begin b.boot_start = 12'h0E00; b.boot_words = 11'h200; b.boot_pages = 6'd16; end
         2'b00: begin b.boot_start = 12'h0C00; b.boot_words = 11'h400; b.boot_pages = 6'd32; end
      endcase
      boot_decode = b;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   fsp_state_t  state_r, state_nxt;
   logic [4:0]  cmd_r, cmd_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic        busy_r, busy_nxt;
   logic        halt_r, halt_nxt;
   fsp_addr_t   addr_r, addr_nxt;
   logic        er_r, er_nxt, wr_r, wr_nxt, lk_r, lk_nxt, ld_r, ld_nxt, re_r, re_nxt;
   fsp_boot_t   boot_r, boot_nxt;
   logic        se_r, se_nxt, fb_r, fb_nxt;
   logic [4:0]  rd_r, rd_nxt;
   logic        legal;

   always_comb begin
      state_nxt = state_r;
      cmd_nxt   = cmd_r;
      cnt_nxt   = cnt_r;
      busy_nxt  = busy_r;
      halt_nxt  = halt_r;
      addr_nxt  = addr_r;
      er_nxt    = 1'b0;
      wr_nxt    = 1'b0;
      lk_nxt    = 1'b0;
      ld_nxt    = 1'b0;
      re_nxt    = 1'b0;
      boot_nxt  = boot_decode({boot_size_sel_hi, boot_size_sel_lo});
      // Power-down sleep means the core issues nothing, so writes are gated here too.
      legal = ctrl_wr && !power_down &&
              (ctrl_wdata == CMD_REENABLE || ctrl_wdata == CMD_LOCKSET ||
               ctrl_wdata == CMD_PGWRITE  || ctrl_wdata == CMD_PGERASE || ctrl_wdata == CMD_PGLOAD);
      // Pointer bits above 12 never reach the address.
      addr_nxt.page    = pointer[pointer_counter_top_bit:pointer_page_offset_top_bit+1];
      addr_nxt.word    = pointer[pointer_page_offset_top_bit:1];
      addr_nxt.byte_hi = pointer[0];
      unique case (state_r)
         ST_IDLE: begin
            if (legal) begin
               cmd_nxt   = ctrl_wdata;
               cnt_nxt   = CNT_W'(ARM_CYC - 1);
               state_nxt = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (store_exec) begin
               unique case (cmd_r)
                  CMD_PGERASE, CMD_PGWRITE: begin
                     er_nxt    = (cmd_r == CMD_PGERASE);
                     wr_nxt    = (cmd_r == CMD_PGWRITE);
                     halt_nxt  = in_halt_region(addr_nxt.page);
                     if (!in_halt_region(addr_nxt.page)) busy_nxt = 1'b1;
                     cnt_nxt   = CNT_W'(PROG_CYC - 1);
                     state_nxt = ST_BUSY;
                  end
                  CMD_LOCKSET: begin
                     lk_nxt    = 1'b1;
                     cnt_nxt   = CNT_W'(PROG_CYC - 1);
                     state_nxt = ST_BUSY;
                  end
                  CMD_REENABLE: begin
                     re_nxt    = 1'b1;
                     busy_nxt  = 1'b0;
                     state_nxt = ST_IDLE;
                  end
                  default: begin
                     ld_nxt    = 1'b1;
                     busy_nxt  = 1'b0;
                     state_nxt = ST_IDLE;
                  end
               endcase
            end else if (cnt_r == '0) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_BUSY: begin
            if (cnt_r == '0) begin
               halt_nxt  = 1'b0;
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      // Reset idles the sequencer, but a timed operation keeps counting through it so that
      // it still ends inside its window; an unknown state at power-up falls to idle here.
      if (!rst_n && !(state_r == ST_BUSY && state_nxt == ST_BUSY)) begin
         state_nxt = ST_IDLE;
         cmd_nxt   = '0;
         cnt_nxt   = '0;
         halt_nxt  = 1'b0;
      end
      se_nxt = (state_nxt != ST_IDLE);
      fb_nxt = (state_nxt == ST_BUSY);
      rd_nxt = se_nxt ? cmd_nxt : 5'h00;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // The sequencing state takes reset through its next-value logic so that a running
   // flash write completes; the enclosing reset tree must keep clk alive meanwhile.
   always_ff @(posedge clk) begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      cnt_r   <= cnt_nxt;
      halt_r  <= halt_nxt;
      se_r    <= se_nxt;
      fb_r    <= fb_nxt;
      rd_r    <= rd_nxt;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         addr_r <= '0;
         er_r   <= 1'b0;
         wr_r   <= 1'b0;
         lk_r   <= 1'b0;
         ld_r   <= 1'b0;
         re_r   <= 1'b0;
         boot_r <= '0;
      end else begin
         busy_r  <= busy_nxt;
         addr_r  <= addr_nxt;
         er_r    <= er_nxt;
         wr_r    <= wr_nxt;
         lk_r    <= lk_nxt;
         ld_r    <= ld_nxt;
         re_r    <= re_nxt;
         boot_r  <= boot_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      store_enable     = se_r;
      flash_busy       = fb_r;
      region_busy_flag = busy_r;
      fetch_stall      = halt_r;
      ctrl_rdata       = rd_r;
      addr_out         = addr_r;
      erase_strobe     = er_r;
      write_strobe     = wr_r;
      lock_strobe      = lk_r;
      load_strobe      = ld_r;
      reenable_strobe  = re_r;
      boot_map         = boot_r;
   end

endmodule

// *** common/fsp_pkg.sv ***
// Package of constants and types for the flash self-programming sequencer.
package fsp_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int  CLK_HZ          = 25_000_000;
   // Whole microseconds keep the cycle counts exact, free of real-number rounding.
   localparam int  PROG_MIN_US     = 3700;
   localparam int  PROG_MAX_US     = 4500;
   localparam int  CYC_PER_US      = CLK_HZ / 1_000_000;
   localparam int  PROG_MIN_CYC    = PROG_MIN_US * CYC_PER_US;
   localparam int  PROG_MAX_CYC    = PROG_MAX_US * CYC_PER_US;
   // A value in the middle of the window keeps margin on both sides.
   localparam int  PROG_CYC        = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
   localparam int  ARM_CYC         = 4;
   localparam int  CNT_W           = 20;

   // ---------------------------------------------------------------
   // Address layout
   // ---------------------------------------------------------------
   localparam int  counter_top_bit             = 11;
   localparam int  page_offset_top_bit         = 4;
   localparam int  pointer_counter_top_bit     = 12;
   localparam int  pointer_page_offset_top_bit = 5;
   localparam logic [11:0] HALT_REGION_BASE    = 12'h0C00;

   // ---------------------------------------------------------------
   // Control patterns on the low five control bits
   // ---------------------------------------------------------------
   localparam logic [4:0] CMD_REENABLE = 5'h11;
   localparam logic [4:0] CMD_LOCKSET  = 5'h09;
   localparam logic [4:0] CMD_PGWRITE  = 5'h05;
   localparam logic [4:0] CMD_PGERASE  = 5'h03;
   localparam logic [4:0] CMD_PGLOAD   = 5'h01;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } fsp_state_t;

   typedef struct packed {
      logic [6:0] page;
      logic [4:0] word;
      logic       byte_hi;
   } fsp_addr_t;

   typedef struct packed {
      logic [11:0] boot_start;
      logic [10:0] boot_words;
      logic [5:0]  boot_pages;
   } fsp_boot_t;

endpackage

// *** dv/fsp_seq_monitor.sv ***
// Checker for the flash self-programming sequencer ports.
module fsp_seq_monitor
   import fsp_pkg::*;
(
   input wire logic      clk,
   input wire logic      rst_n,
   input wire logic      ctrl_wr,
   input wire logic [4:0] ctrl_wdata,
   input wire logic      store_exec,
   input wire logic      power_down,
   input wire logic [15:0] pointer,
   input wire logic      boot_size_sel_hi,
   input wire logic      boot_size_sel_lo,
   input wire logic      store_enable,
   input wire logic      region_busy_flag,
   input wire logic [4:0] ctrl_rdata,
   input wire logic      fetch_stall,
   input wire logic      flash_busy,
   input wire fsp_addr_t addr_out,
   input wire logic      erase_strobe,
   input wire logic      write_strobe,
   input wire fsp_boot_t boot_map
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------
   // Helpers
   // --------
   logic [CNT_W-1:0] busy_cnt;
   logic             legal;
   logic [12:0]      ptr_low;
   logic [1:0]       size_sel;
   assign legal = ctrl_wdata inside {CMD_REENABLE, CMD_LOCKSET, CMD_PGWRITE, CMD_PGERASE, CMD_PGLOAD};
   assign ptr_low = pointer[12:0];
   assign size_sel = {boot_size_sel_hi, boot_size_sel_lo};
   // No reset here: a timed operation runs on through reset.
   always_ff @(posedge clk) busy_cnt <= flash_busy ? busy_cnt + 1'b1 : '0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_armed_idle;
      $rose(store_enable) ##0 (!store_exec && !flash_busy) [*4];
   endsequence
   sequence s_start;
      store_enable && !flash_busy && store_exec;
   endsequence
   arm_window_a: assert property (ctrl_wr && legal && !power_down && !store_enable |=> store_enable)
      else $error("store enable not armed");
   bad_cmd_a: assert property (ctrl_wr && !legal && !store_enable |=> !store_enable)
      else $error("illegal pattern accepted");
   sleep_block_a: assert property (ctrl_wr && power_down && !store_enable |=> !store_enable)
      else $error("write accepted in sleep");
   arm_expire_a: assert property (s_armed_idle |=> !store_enable)
      else $error("arm window too long");
   erase_start_a: assert property (s_start ##0 ctrl_rdata == CMD_PGERASE |=> erase_strobe && flash_busy)
      else $error("erase did not start");
   halt_stall_a: assert property ((erase_strobe || write_strobe) && addr_out.page >= 7'h60 |-> fetch_stall)
      else $error("no stall for halting region");
   rww_flag_a: assert property ((erase_strobe || write_strobe) && addr_out.page < 7'h60 |-> region_busy_flag)
      else $error("region flag not set");
   busy_max_a: assert property (flash_busy |-> busy_cnt < PROG_MAX_CYC)
      else $error("operation too long");
   busy_end_a: assert property ($fell(flash_busy) |-> busy_cnt >= PROG_MIN_CYC && !fetch_stall)
      else $error("operation too short");
   addr_split_a: assert property (1'b1 |=> addr_out == $past(ptr_low))
      else $error("address split wrong");
   boot_map_a: assert property (1'b1 |=> boot_map.boot_start == 16'h1000 - (16'h0400 >> $past(size_sel)))
      else $error("boot start wrong");
endmodule
bind fsp_seq fsp_seq_monitor mon_u (.*);

// *** dv/fsp_core_model.sv ***
// Core-side model issuing control writes and store instructions.
module fsp_core_model
   import fsp_pkg::*;
(
   input  wire logic        clk,
   output logic             ctrl_wr,
   output logic [4:0]       ctrl_wdata,
   output logic             store_exec,
   output logic [15:0]      pointer,
   output logic             power_down
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 5'h00;
      store_exec = 1'b0;
      pointer = 16'h0000;
      power_down = 1'b0;
   end
   // --------
   // Store sequence: gap is the cycle of the store after the write, 0 for none.
   // --------
   task automatic issue(input logic [4:0] c, input logic [15:0] p, input int gap);
      @(posedge clk);
      #1;
      pointer = (c == CMD_PGWRITE) ? (p & 16'hFFC0) : (p & 16'hFFFE);
      ctrl_wdata = c;
      ctrl_wr = 1'b1;
      @(posedge clk);
      #1;
      ctrl_wr = 1'b0;
      if (gap > 0) begin
         repeat (gap - 1) begin
            @(posedge clk);
            #1;
         end
         store_exec = 1'b1;
         @(posedge clk);
         #1;
         store_exec = 1'b0;
      end
   endtask
endmodule

// *** dv/fsp_seq_tb.sv ***
// Self-checking testbench for the flash self-programming sequencer.
module fsp_seq_tb;
   import fsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, boot_size_sel_hi = 1'b0, boot_size_sel_lo = 1'b0;
   logic ctrl_wr, store_exec, power_down, store_enable, region_busy_flag, fetch_stall, flash_busy;
   logic erase_strobe, write_strobe, lock_strobe, load_strobe, reenable_strobe;
   logic [4:0]  ctrl_wdata, ctrl_rdata;
   logic [15:0] pointer;
   fsp_addr_t   addr_out;
   fsp_boot_t   boot_map;
   int fail_count = 0, total_checks = 0, cycles = 0, n;
   always #20 clk = ~clk;
   fsp_core_model core_u (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .store_exec(store_exec),
      .pointer(pointer), .power_down(power_down));
   fsp_seq dut_u (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .store_exec(store_exec),
      .load_exec(1'b0), .pointer(pointer), .power_down(power_down), .boot_size_sel_hi(boot_size_sel_hi),
      .boot_size_sel_lo(boot_size_sel_lo), .store_enable(store_enable), .region_busy_flag(region_busy_flag),
      .ctrl_rdata(ctrl_rdata), .fetch_stall(fetch_stall), .flash_busy(flash_busy), .addr_out(addr_out),
      .erase_strobe(erase_strobe), .write_strobe(write_strobe), .lock_strobe(lock_strobe),
      .load_strobe(load_strobe), .reenable_strobe(reenable_strobe), .boot_map(boot_map));
   // --------
   // Checking and closing
   // --------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // The single timed operation needs about 102500 cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 120000) begin
         fail_count++;
         results();
      end
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic t_map();
      for (int i = 0; i < 4; i++) begin
         {boot_size_sel_hi, boot_size_sel_lo} = 2'(i);
         core_u.pointer = 16'hE5A7 + 16'(i) * 16'h1111;
         step();
         step();
         chk(boot_map.boot_start, 32'h1000 - (32'h0400 >> i));
         chk(boot_map.boot_pages, 32'h20 >> i);
         chk(boot_map.boot_words, 32'h400 >> i);
         chk(addr_out, {pointer[12:6], pointer[5:1], pointer[0]});
      end
   endtask
   task automatic t_arm();
      core_u.issue(CMD_PGLOAD, 16'h0000, 0);
      chk(ctrl_rdata, CMD_PGLOAD);
      for (int k = 0; k < 4; k++) begin
         chk(store_enable, 1);
         step();
      end
      chk(store_enable, 0);
      core_u.issue(5'h07, 16'h0000, 0);
      step();
      chk(store_enable, 0);
      core_u.power_down = 1'b1;
      core_u.issue(CMD_PGLOAD, 16'h0000, 0);
      step();
      chk(store_enable, 0);
      core_u.power_down = 1'b0;
   endtask
   task automatic t_late();
      core_u.issue(CMD_PGWRITE, 16'h0000, 5);
      step();
      chk({write_strobe, flash_busy}, 0);
      core_u.issue(CMD_LOCKSET, 16'h0001, 5);
      step();
      chk({lock_strobe, flash_busy}, 0);
      core_u.issue(CMD_PGLOAD, 16'h0042, 4);
      chk(load_strobe, 1);
      core_u.issue(CMD_REENABLE, 16'h0000, 1);
      chk(reenable_strobe, 1);
   endtask
   task automatic t_erase();
      core_u.issue(CMD_PGERASE, 16'h3F00, 1);
      chk({erase_strobe, flash_busy, fetch_stall, region_busy_flag}, 4'b1110);
      n = 0;
      while (flash_busy === 1'b1 && n < 110000) begin
         step();
         n++;
         if (n == 500) rst_n = 1'b0;
         if (n == 502) begin
            chk({flash_busy, fetch_stall}, 2'b11);
            rst_n = 1'b1;
         end
      end
      chk(n >= PROG_MIN_CYC && n <= PROG_MAX_CYC, 1);
      chk({fetch_stall, store_enable}, 0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_map();
      t_arm();
      t_late();
      t_erase();
      results();
   end
endmodule
